// ===== pkg/pss_pkg.sv
// Package with register map, field positions and reset values of the soft strap block.
package pss_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] pss_idx_one = 8'h09;
    localparam logic [7:0] pss_idx_two = 8'h0a;
    localparam logic [7:0] pss_idx_three = 8'h0b;
    // Field positions in strap_control_one.
    localparam int pss_one_cfg_done = 15;
    // Field positions in strap_control_two.
    localparam int pss_two_fast_linkup = 6;
    localparam int pss_two_ext_fd = 5;
    localparam int pss_two_enh_led = 4;
    localparam int pss_two_iso_hd = 3;
    localparam int pss_two_idle_err = 2;
    localparam int pss_two_odd_dis = 1;
    localparam int pss_two_rx_clk_sel = 0;
    // Field positions in strap_control_three.
    localparam int pss_three_pol_swap = 6;
    localparam int pss_three_pair_swap = 5;
    localparam int pss_three_bypass = 4;
    // Writable masks and reset values.
    localparam logic [15:0] pss_one_mask = 16'h8000;
    localparam logic [15:0] pss_two_mask = 16'h3fff;
    localparam logic [15:0] pss_three_mask = 16'h007f;
    localparam logic [15:0] pss_one_reset = 16'h0000;
    localparam logic [15:0] pss_two_reset = 16'h0004;
    localparam logic [15:0] pss_three_reset = 16'h0000;
    // Length of the internal reset pulse, in cycles.
    localparam logic [1:0] pss_rst_pulse_cycles = 2'h1;

    // Transmit nibble tracker states.
    typedef enum logic [2:0] {
        pss_tx_idle = 3'b001,
        pss_tx_run = 3'b010,
        pss_tx_ext = 3'b100
    } pss_tx_type;
endpackage : pss_pkg

// ===== rtl/pss_strap_config.sv
// Soft strap configuration register bank with APB slave and strap-driven behaviour.
//
// Contract
// - Extended FD clear: standard duplex decision.
// - Enhanced LED: link LED only 100TX FD.
// - Isolate bit: isolate MII on 100TX HD.
// - Idle error bit enables idle symbol errors.
// - Odd nibble end: extend TX_EN, force error.
// - RMII receive clock select: RX_CLK or crystal.
// - Config done: internal reset pulse, latch straps.
// - Third register bits 15:7 read zero.
// - Polarity swap inverts both pairs.
// - Pair swap exchanges transmit and receive pairs.
// - Port mirror needs both swap bits set.
// - 4B/5B bypass, valid only in MII.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pss_strap_config (
    input wire logic pclk, // APB clock, 200 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [31:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    input wire logic [3:0] pstrb, // APB byte strobes.
    output logic [31:0] prdata, // APB read data, registered.
    output logic pready, // APB ready, combinational.
    output logic pslverr, // APB error for unmapped address, registered.
    input wire logic link_up, // Link established, same clock domain.
    input wire logic link_100, // Link runs at 100 Mb/s.
    input wire logic an_full_duplex, // Duplex chosen by standard negotiation.
    input wire logic partner_forced_100, // Link partner forced to 100BASE-TX.
    input wire logic mii_mode, // MAC interface is MII, not RMII.
    input wire logic rx_idle, // Receiver is in the IDLE state.
    input wire logic rx_symbol_err, // Symbol error seen by the receiver.
    input wire logic tx_en, // Transmit enable from the MAC.
    input wire logic tx_er, // Transmit error from the MAC.
    output logic full_duplex, // Resolved duplex, high for full.
    output logic led_link, // Link indicator, high for on.
    output logic mii_isolate, // MII outputs isolated.
    output logic idle_rx_err, // Idle symbol error flag, registered, high one cycle after each cycle with the error.
    output logic tx_en_int, // Internal transmit enable with extension.
    output logic tx_er_int, // Internal transmit error with forced cycle.
    output logic rx_clk_sel, // High: receive data timed by RX_CLK.
    output logic polarity_swap, // Invert both pairs.
    output logic pair_swap, // Receive on transmit-named pair.
    output logic port_mirror, // Port mirroring enabled.
    output logic bypass_4b5b, // 4B/5B encoder and decoder bypassed.
    output logic fast_linkup_pd, // Fast link-up during parallel detection.
    output logic cfg_reset // Internal reset pulse after config done.
);
    import pss_pkg::*;

    // Whole state of the block in one register.
    typedef struct packed {
        logic [15:0] one; // Software copy of strap_control_one.
        logic [15:0] two; // Software copy of strap_control_two.
        logic [15:0] three; // Software copy of strap_control_three.
        logic [15:0] cfg_two; // Latched configuration from strap_control_two.
        logic [15:0] cfg_three; // Latched configuration from strap_control_three.
        logic [1:0] rst_cnt; // Remaining cycles of the internal reset pulse.
        logic [31:0] rdata; // Read data held for the access phase.
        logic err; // Error answer held for the access phase.
        pss_tx_type tx_state; // Transmit nibble tracker.
        logic odd; // Odd number of nibbles sent so far.
        logic tx_en_o; // Registered internal transmit enable.
        logic tx_er_o; // Registered internal transmit error.
        logic idle_err; // Registered idle symbol error flag.
        logic led; // Registered link indicator.
        logic iso; // Registered isolation state.
        logic fd; // Registered duplex.
    } pss_state_type;

    pss_state_type state;
    pss_state_type next_state;
    logic [7:0] index; // Word index decoded from the byte address.
    logic mapped; // Address hits one of the three registers.
    logic access; // Access phase completes this cycle.
    logic [15:0] wmask; // Byte strobe mask on the low half word.

    // The slave never inserts wait states, so every access phase ends at once.
    assign pready = psel & penable;
    assign prdata = state.rdata;
    assign pslverr = state.err & psel & penable;
    assign index = paddr[9:2];
    assign access = psel & penable;
    assign mapped = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0) &&
        (index == pss_idx_one || index == pss_idx_two || index == pss_idx_three);
    assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Outputs driven from the latched configuration, not the software copies.
    assign rx_clk_sel = state.cfg_two[pss_two_rx_clk_sel];
    assign polarity_swap = state.cfg_three[pss_three_pol_swap];
    assign pair_swap = state.cfg_three[pss_three_pair_swap];
    assign port_mirror = state.cfg_three[pss_three_pol_swap] & state.cfg_three[pss_three_pair_swap];
    assign bypass_4b5b = state.cfg_three[pss_three_bypass] & mii_mode;
    assign fast_linkup_pd = state.cfg_two[pss_two_fast_linkup];
    assign cfg_reset = (state.rst_cnt != 2'h0);
    assign full_duplex = state.fd;
    assign led_link = state.led;
    assign mii_isolate = state.iso;
    assign idle_rx_err = state.idle_err;
    assign tx_en_int = state.tx_en_o;
    assign tx_er_int = state.tx_er_o;

    // Next-state logic: bus slave, strap latch and behaviour taps.
    always_comb begin
        next_state = state;
        // Read data is prepared in the setup cycle so that it comes from a flop.
        if (psel && !penable) begin
            next_state.err = !mapped;
            case (index)
                pss_idx_one: next_state.rdata = {16'h0000, state.one};
                pss_idx_two: next_state.rdata = {16'h0000, state.two};
                pss_idx_three: next_state.rdata = {16'h0000, state.three & pss_three_mask};
                default: next_state.rdata = 32'h00000000;
            endcase
            if (!mapped) begin
                next_state.rdata = 32'h00000000;
            end
        end
        // Writes take effect only at the completing edge; reserved bits stay zero.
        if (access && pwrite && mapped) begin
            case (index)
                pss_idx_one: begin
                    next_state.one = (state.one & ~(pss_one_mask & wmask)) | (pwdata[15:0] & pss_one_mask & wmask);
                end
                pss_idx_two: begin
                    next_state.two = (state.two & ~(pss_two_mask & wmask)) | (pwdata[15:0] & pss_two_mask & wmask);
                end
                pss_idx_three: begin
                    next_state.three = (state.three & ~(pss_three_mask & wmask)) |
                        (pwdata[15:0] & pss_three_mask & wmask);
                end
                default: begin
                end
            endcase
        end
        // Config done written as one starts the reset pulse; software owns the sequence.
        if (access && pwrite && mapped && index == pss_idx_one && pstrb[1] &&
            pwdata[pss_one_cfg_done]) begin
            next_state.rst_cnt = pss_rst_pulse_cycles;
        end else if (state.rst_cnt != 2'h0) begin
            next_state.rst_cnt = state.rst_cnt - 2'h1;
        end
        // The straps are latched while the pulse is high, so they apply after it ends.
        if (state.rst_cnt != 2'h0) begin
            next_state.cfg_two = state.two;
            next_state.cfg_three = state.three;
        end
        // Duplex: forced full only with the extended bit set and a forced-100 partner.
        if (state.cfg_two[pss_two_ext_fd] && link_100 && partner_forced_100) begin
            next_state.fd = 1'b1;
        end else begin
            next_state.fd = an_full_duplex;
        end
        // Link indicator qualified by 100TX full duplex when enhanced mode is on.
        if (state.cfg_two[pss_two_enh_led]) begin
            next_state.led = link_up & link_100 & next_state.fd;
        end else begin
            next_state.led = link_up;
        end
        // Isolation only on a 100TX half-duplex link.
        next_state.iso = state.cfg_two[pss_two_iso_hd] & link_up & link_100 & !next_state.fd;
        // Idle symbol errors are reported only when enabled.
        next_state.idle_err = state.cfg_two[pss_two_idle_err] & rx_idle & rx_symbol_err;
        // Transmit tracker: each cycle of tx_en carries one nibble.
        next_state.tx_en_o = tx_en;
        next_state.tx_er_o = tx_er;
        case (state.tx_state)
            pss_tx_idle: begin
                if (tx_en) begin
                    next_state.tx_state = pss_tx_run;
                    next_state.odd = 1'b1;
                end
            end
            pss_tx_run: begin
                if (tx_en) begin
                    next_state.odd = !state.odd;
                end else if (state.odd && !state.cfg_two[pss_two_odd_dis]) begin
                    // Frame ended mid-byte: stretch one cycle and flag it as an error.
                    next_state.tx_state = pss_tx_ext;
                    next_state.tx_en_o = 1'b1;
                    next_state.tx_er_o = 1'b1;
                end else begin
                    next_state.tx_state = pss_tx_idle;
                end
            end
            pss_tx_ext: begin
                // A new frame in the stretch cycle starts a fresh count.
                next_state.tx_state = tx_en ? pss_tx_run : pss_tx_idle;
                next_state.odd = tx_en;
            end
            default: begin
                next_state.tx_state = pss_tx_idle;
                next_state.odd = 1'b0;
            end
        endcase
    end

    // State register; the latched configuration starts at the documented defaults.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '{one: pss_one_reset, two: pss_two_reset, three: pss_three_reset,
                cfg_two: pss_two_reset, cfg_three: pss_three_reset, rst_cnt: 2'h0,
                rdata: 32'h00000000, err: 1'b0, tx_state: pss_tx_idle, odd: 1'b0,
                tx_en_o: 1'b0, tx_er_o: 1'b0, idle_err: 1'b0, led: 1'b0, iso: 1'b0, fd: 1'b0};
        end else begin
            state <= next_state;
        end
    end
endmodule : pss_strap_config
`default_nettype wire

// ===== verification/pss_strap_config_properties.sv
// Port-level checker for the soft strap block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module pss_props_chk (
    input wire logic pclk, presetn, // Clock and reset, active low.
    input wire logic psel, penable, pwrite, // Bus controls.
    input wire logic [31:0] paddr, pwdata, prdata, // Bus address and data.
    input wire logic [3:0] pstrb, // Byte strobes.
    input wire logic link_up, link_100, rx_idle, rx_symbol_err, // Line status.
    input wire logic tx_en, tx_er, mii_mode, full_duplex, led_link, // Transmit and mode.
    input wire logic mii_isolate, idle_rx_err, tx_en_int, tx_er_int, // Derived behaviour.
    input wire logic polarity_swap, pair_swap, port_mirror, bypass_4b5b, cfg_reset // Latched straps.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Config done written to one, then a single pulse.
    sequence s_done_wr;
        psel && penable && pwrite && paddr == 32'h24 && pwdata[15] && pstrb[1];
    endsequence
    sequence s_pulse;
        cfg_reset ##1 !cfg_reset;
    endsequence
    property p_cfg; s_done_wr |=> s_pulse; endproperty
    a_cfg: assert property (p_cfg) else $error("cfg pulse wrong");
    property p_led; led_link |-> $past(link_up); endproperty
    a_led: assert property (p_led) else $error("led without link");
    property p_iso; mii_isolate |-> !full_duplex && $past(link_up && link_100); endproperty
    a_iso: assert property (p_iso) else $error("isolate wrong");
    property p_idle; idle_rx_err |-> $past(rx_idle && rx_symbol_err); endproperty
    a_idle: assert property (p_idle) else $error("idle error without cause");
    // A forced error cycle only follows a transmit enable that just ended.
    property p_odd; tx_er_int && !$past(tx_er) |-> tx_en_int && !$past(tx_en) && $past(tx_en, 2); endproperty
    a_odd: assert property (p_odd) else $error("extension cycle wrong");
    property p_res; psel && penable && !pwrite && paddr == 32'h2c |-> prdata[31:7] == 25'h0; endproperty
    a_res: assert property (p_res) else $error("reserved bits not zero");
    property p_mir; port_mirror == (polarity_swap && pair_swap); endproperty
    a_mir: assert property (p_mir) else $error("mirror wrong");
    property p_byp; bypass_4b5b |-> mii_mode; endproperty
    a_byp: assert property (p_byp) else $error("bypass outside mii");
endmodule : pss_props_chk
bind pss_strap_config pss_props_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pstrb, .link_up, .link_100, .rx_idle, .rx_symbol_err, .tx_en, .tx_er, .mii_mode, .full_duplex, .led_link,
    .mii_isolate, .idle_rx_err, .tx_en_int, .tx_er_int, .polarity_swap, .pair_swap, .port_mirror, .bypass_4b5b,
    .cfg_reset);
`default_nettype wire

// ===== verification/pss_strap_config_tb.sv
// Self-checking testbench of the soft strap block.
`timescale 1ns/1ps
`default_nettype none
module pss_strap_config_tb;
    import pss_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, link_up, link_100, an_full_duplex, partner_forced_100, mii_mode;
    logic rx_idle, rx_symbol_err, tx_en, tx_er, pready, pslverr, full_duplex, led_link, mii_isolate, idle_rx_err;
    logic tx_en_int, tx_er_int, rx_clk_sel, polarity_swap, pair_swap, port_mirror, bypass_4b5b, fast_linkup_pd;
    logic cfg_reset, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [3:0] pstrb;
    int n_fail, samples_checked;
    pss_strap_config i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .link_up, .link_100, .an_full_duplex, .partner_forced_100, .mii_mode, .rx_idle, .rx_symbol_err,
        .tx_en, .tx_er, .full_duplex, .led_link, .mii_isolate, .idle_rx_err, .tx_en_int, .tx_er_int, .rx_clk_sel,
        .polarity_swap, .pair_swap, .port_mirror, .bypass_4b5b, .fast_linkup_pd, .cfg_reset);
    // Free-running 200 MHz clock.
    initial begin
        pclk = 0;
        forever #2.5 pclk = ~pclk;
    end
    // Byte address of a register index.
    function automatic logic [31:0] ba(input logic [7:0] x);
        return {22'h0, x, 2'b00};
    endfunction : ba
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One bus transfer; read data and error are taken at the edge that sees ready.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic t_regs;
        apb(0, ba(pss_idx_one), 0); chk("one", rd, 32'h0);
        apb(0, ba(pss_idx_two), 0); chk("two", rd, 32'h4);
        apb(1, ba(pss_idx_three), 32'hffffffff);
        apb(0, ba(pss_idx_three), 0); chk("three", rd, 32'h7f);
        chk("pol early", polarity_swap, 0);
        apb(0, 32'h30, 0); chk("slverr", err, 1);
        apb(1, ba(pss_idx_three), 0);
    endtask : t_regs
    task automatic t_idle(input logic exp);
        @(posedge pclk); {rx_idle, rx_symbol_err} <= 2'b11;
        @(posedge pclk); {rx_idle, rx_symbol_err} <= 2'b00;
        #1 chk("idle", idle_rx_err, exp);
    endtask : t_idle
    // Odd length frames gain one extension cycle carrying an error.
    task automatic t_tx(input int n, input int ext);
        int ne, ner;
        ne = 0;
        ner = 0;
        for (int i = 0; i < n + 8; i++) begin
            @(posedge pclk); tx_en <= (i < n);
            ne += tx_en_int;
            ner += tx_er_int;
        end
        chk("tx_en_int", 32'(ne), 32'(n + ext));
        chk("tx_er_int", 32'(ner), 32'(ext));
    endtask : t_tx
    task automatic t_link(input logic enh);
        for (int f = 0; f < 2; f++) begin
            @(posedge pclk); {link_up, link_100, an_full_duplex} <= {2'b11, f[0]};
            repeat (3) @(posedge pclk);
            #1 chk("fd", full_duplex, f[0]);
            chk("led", led_link, enh ? f[0] : 1'b1);
            chk("iso", mii_isolate, enh & !f[0]);
        end
        @(posedge pclk); link_up <= 0;
    endtask : t_link
    task automatic t_cfg;
        int i;
        apb(1, ba(pss_idx_three), 32'h70);
        apb(1, ba(pss_idx_two), 32'h59);
        apb(0, ba(pss_idx_two), 0); chk("two rd", rd, 32'h59);
        chk("fast linkup early", fast_linkup_pd, 0);
        // Straps are written first, config done last.
        apb(1, ba(pss_idx_one), 32'h8000);
        // Outputs are looked at 1 ns after the edge, once the flops have settled.
        #1;
        for (i = 0; i < 4 && cfg_reset !== 1'b1; i++) begin
            @(posedge pclk);
            #1;
        end
        chk("cfg pulse", cfg_reset, 1);
        @(posedge pclk); #1 chk("cfg end", cfg_reset, 0);
        repeat (2) @(posedge pclk);
        #1 chk("straps", {rx_clk_sel, polarity_swap, pair_swap, port_mirror, bypass_4b5b}, 5'h1f);
        chk("fast linkup", fast_linkup_pd, 1);
        @(posedge pclk); mii_mode <= 0;
        @(posedge pclk); #1 chk("bypass rmii", bypass_4b5b, 0);
        mii_mode <= 1;
    endtask : t_cfg
    initial begin
        {psel, penable, pwrite, link_up, link_100, an_full_duplex, partner_forced_100} = '0;
        {rx_idle, rx_symbol_err, tx_en, tx_er, mii_mode, paddr, pwdata, pstrb} = {5'h1, 64'h0, 4'hf};
        {presetn, n_fail, samples_checked} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_idle(1);
        t_tx(3, 1);
        t_tx(2, 0);
        t_link(0);
        t_cfg();
        t_idle(0);
        t_link(1);
        conclude();
    end
endmodule : pss_strap_config_tb
`default_nettype wire
